// ---- design/fmsp_serial_port_regs.vh ----
// Purpose: Constants for the four-mode serial port.
// Assumes: Core clock drives every register; register access is by dedicated strobes.
// Notes: Bit positions refer to the serial_port_control byte.
`ifndef FMSP_SERIAL_PORT_REGS_VH
`define FMSP_SERIAL_PORT_REGS_VH

// ----------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------
`define FMSP_CTRL_RESET 8'h00
`define FMSP_BIT_MODE_HI 7
`define FMSP_BIT_MODE_LO 6
`define FMSP_BIT_FILTER 5
`define FMSP_BIT_RX_ALLOW 4
`define FMSP_BIT_TX_NINTH 3
`define FMSP_BIT_RX_NINTH 2
`define FMSP_BIT_TX_DONE 1
`define FMSP_BIT_RX_DONE 0

// ----------------------------------------------------------------
// Mode codes and timing
// ----------------------------------------------------------------
`define FMSP_MODE_SHIFT 2'h0
`define FMSP_MODE_UART8 2'h1
`define FMSP_MODE_UART9_FIXED 2'h2
`define FMSP_MODE_UART9_VAR 2'h3
// Shift mode bit period is 12 core clocks, split into two 6-clock phases.
`define FMSP_SHIFT_HALF_DIV 3'h6
// Fixed 9-bit mode: 16 sample ticks per bit, so 64/16 or 32/16 clocks per tick.
`define FMSP_FIXED_DIV64_TICK 3'h4
`define FMSP_FIXED_DIV32_TICK 3'h2
`define FMSP_TICKS_PER_BIT 4'hf
`define FMSP_MID_TICK 4'h7
`define FMSP_LAST_BIT_UART8 4'h9
`define FMSP_LAST_BIT_UART9 4'ha
`define FMSP_SHIFT_LAST_BIT 3'h7
`define FMSP_IDLE_LINE 1'b1

`endif

// ---- design/fmsp_baud_gen.v ----
// Purpose: Sample tick generation for all four serial modes.
// Assumes: Timer overflow inputs are one-cycle pulses.
// Notes: Ticks are sixteen per bit in the UART modes, two per bit in shift mode.
`timescale 1ns/10ps
`include "fmsp_serial_port_regs.vh"

module fmsp_baud_gen (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Configuration
  input wire [1:0] mode,
  input wire baud_doubler,
  input wire tx_timer_select,
  input wire rx_timer_select,
  // Timer overflows
  input wire timer1_ovf,
  input wire timer2_ovf,
  // Ticks
  output wire shift_tick,
  output wire tx_tick,
  output wire rx_tick
);
  reg [2:0] div_reg;
  reg [2:0] div_next;
  wire [2:0] limit;
  wire fixed_tick;
  wire var_mode;

  assign limit = (mode == `FMSP_MODE_SHIFT) ? `FMSP_SHIFT_HALF_DIV :
                 baud_doubler ? `FMSP_FIXED_DIV32_TICK : `FMSP_FIXED_DIV64_TICK;
  assign fixed_tick = (div_reg == limit - 3'h1);
  assign shift_tick = fixed_tick && (mode == `FMSP_MODE_SHIFT);
  assign var_mode = (mode == `FMSP_MODE_UART8) || (mode == `FMSP_MODE_UART9_VAR);
  // Each overflow is one of the sixteen samples in a bit period.
  assign tx_tick = var_mode ? (tx_timer_select ? timer2_ovf : timer1_ovf) : fixed_tick;
  assign rx_tick = var_mode ? (rx_timer_select ? timer2_ovf : timer1_ovf) : fixed_tick;

  always @* begin
    div_next = fixed_tick ? 3'h0 : div_reg + 3'h1;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule

// ---- design/fmsp_rx_fifo.v ----
// Purpose: Two-entry buffer between the receive shifter and the receive register.
// Assumes: The drain side stalls while an unread byte is pending.
// Notes: Full and empty are exact; in_ready drops when both entries hold data.
`timescale 1ns/10ps

module fmsp_rx_fifo (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [8:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [8:0] out_data
);
  reg [8:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  genvar i;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  generate
    for (i = 0; i < 2; i = i + 1) begin : g_entry
      always @(posedge clock) begin
        if (!rst_n) begin
          mem_reg[i] <= 9'h000;
        end else if (push && (wr_ptr_reg == i)) begin
          mem_reg[i] <= in_data;
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

// ---- design/fmsp_serial_port.v ----
// Purpose: Four-mode full-duplex serial port with control and buffer registers.
// Assumes: Register strobes and pins are synchronous to clock; timer overflows are pulses.
// Notes: Shift mode runs at one twelfth of the core clock.
`timescale 1ns/10ps
`include "fmsp_serial_port_regs.vh"

// Function
// - Two mode bits select one of four modes
// - Fixed 9-bit mode: clock over 64 or 32
// - Shift mode clock fixed; one twelfth chosen
// - 8-bit filter: need valid stop bit
// - 9-bit filter: suppress flag when ninth bit 0
// - Receive only while receive-allow set
// - Send transmit ninth bit after data
// - Ninth bit field captures ninth or stop
// - Transmit-done timing per mode; software clears
// - Receive-done timing per mode; software clears
// - Shift mode: data on rxd, clock txd
// - Shift receive starts when allowed, flag clear
// - 8-bit frame: start, eight data, stop
// - 8-bit write loads stop in ninth position
// - Receiver starts on falling edge when allowed
// - Final shift loads byte if flag clear, filtered
// - 9-bit frame carries eleven bits
// - 9-bit transmit starts on next baud tick
// - Variable 9-bit mode uses timer ticks
// - Buffer write starts transmit in every mode
// - Variable modes clocked by timer overflows
// - Write and read buffers physically separate
// - New byte lost while previous unread
// - Timer select chooses timer 2 or 1
// - Sixteen overflows per bit period
module fmsp_serial_port (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control register access
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  output wire [7:0] ctrl_rdata,
  // Buffer register access
  input wire buf_wr,
  input wire [7:0] buf_wdata,
  output wire [7:0] buf_rdata,
  // Baud configuration and timer overflows
  input wire baud_doubler,
  input wire tx_timer_select,
  input wire rx_timer_select,
  input wire timer1_ovf,
  input wire timer2_ovf,
  // Serial pins
  input wire rxd_in,
  output wire rxd_out,
  output wire rxd_oe,
  output wire txd_out
);
  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  reg [1:0] mode_reg;
  reg multiproc_filter_reg;
  reg rx_allow_reg;
  reg tx_ninth_bit_reg;
  reg rx_ninth_bit_reg;
  reg tx_done_flag_reg;
  reg rx_done_flag_reg;
  reg [7:0] rx_data_reg;
  wire tx_done_set;
  wire fifo_pop;
  wire [8:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_in_ready;

  assign ctrl_rdata = {mode_reg, multiproc_filter_reg, rx_allow_reg, tx_ninth_bit_reg,
                       rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
  assign buf_rdata = rx_data_reg;
  // A new byte reaches the receive register only after software clears the flag.
  assign fifo_pop = fifo_out_valid && !rx_done_flag_reg;

  always @(posedge clock) begin
    if (!rst_n) begin
      {mode_reg, multiproc_filter_reg, rx_allow_reg, tx_ninth_bit_reg, rx_ninth_bit_reg,
       tx_done_flag_reg, rx_done_flag_reg} <= `FMSP_CTRL_RESET;
      rx_data_reg <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        mode_reg <= ctrl_wdata[`FMSP_BIT_MODE_HI:`FMSP_BIT_MODE_LO];
        multiproc_filter_reg <= ctrl_wdata[`FMSP_BIT_FILTER];
        rx_allow_reg <= ctrl_wdata[`FMSP_BIT_RX_ALLOW];
        tx_ninth_bit_reg <= ctrl_wdata[`FMSP_BIT_TX_NINTH];
      end
      // Hardware set wins over a software write in the same cycle.
      if (tx_done_set) begin
        tx_done_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
        tx_done_flag_reg <= ctrl_wdata[`FMSP_BIT_TX_DONE];
      end
      if (fifo_pop) begin
        rx_done_flag_reg <= 1'b1;
        rx_data_reg <= fifo_out_data[7:0];
        rx_ninth_bit_reg <= fifo_out_data[8];
      end else if (ctrl_wr) begin
        rx_done_flag_reg <= ctrl_wdata[`FMSP_BIT_RX_DONE];
        rx_ninth_bit_reg <= ctrl_wdata[`FMSP_BIT_RX_NINTH];
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud ticks
  // ----------------------------------------------------------------
  wire shift_tick;
  wire tx_tick;
  wire rx_tick;

  fmsp_baud_gen u_baud (
    .clock(clock),
    .rst_n(rst_n),
    .mode(mode_reg),
    .baud_doubler(baud_doubler),
    .tx_timer_select(tx_timer_select),
    .rx_timer_select(rx_timer_select),
    .timer1_ovf(timer1_ovf),
    .timer2_ovf(timer2_ovf),
    .shift_tick(shift_tick),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick)
  );

  wire shift_mode;
  wire nine_bit;
  assign shift_mode = (mode_reg == `FMSP_MODE_SHIFT);
  assign nine_bit = mode_reg[1];

  // ----------------------------------------------------------------
  // Transmitter, also the shift-mode engine in both directions
  // ----------------------------------------------------------------
  reg tx_busy_reg;
  reg tx_wait_reg;
  reg [10:0] tx_sh_reg;
  reg [3:0] tx_bit_reg;
  reg [3:0] tx_cnt_reg;
  reg txd_reg;
  reg m0_busy_reg;
  reg m0_rx_reg;
  reg m0_phase_reg;
  reg [2:0] m0_bit_reg;
  reg [7:0] m0_sh_reg;
  reg rxd_out_reg;
  reg rxd_oe_reg;
  wire [3:0] tx_last_bit;
  wire m0_rx_start;
  wire m0_done;
  wire [7:0] m0_rx_byte;

  assign txd_out = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;
  assign tx_last_bit = nine_bit ? `FMSP_LAST_BIT_UART9 : `FMSP_LAST_BIT_UART8;
  assign m0_rx_start = shift_mode && rx_allow_reg && !rx_done_flag_reg && !m0_busy_reg &&
                       !buf_wr && !fifo_out_valid;
  assign m0_done = m0_busy_reg && shift_tick && m0_phase_reg &&
                   (m0_bit_reg == `FMSP_SHIFT_LAST_BIT);
  assign m0_rx_byte = {rxd_in, m0_sh_reg[7:1]};
  assign tx_done_set = (m0_done && !m0_rx_reg) ||
                       (tx_busy_reg && !tx_wait_reg && tx_tick &&
                        (tx_cnt_reg == `FMSP_TICKS_PER_BIT) &&
                        (tx_bit_reg + 4'h1 == tx_last_bit));

  always @(posedge clock) begin
    if (!rst_n) begin
      tx_busy_reg <= 1'b0;
      tx_wait_reg <= 1'b0;
      tx_sh_reg <= 11'h7ff;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 4'h0;
      txd_reg <= `FMSP_IDLE_LINE;
      m0_busy_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_phase_reg <= 1'b0;
      m0_bit_reg <= 3'h0;
      m0_sh_reg <= 8'h00;
      rxd_out_reg <= `FMSP_IDLE_LINE;
      rxd_oe_reg <= 1'b0;
    end else if (buf_wr && shift_mode) begin
      // Shift mode transmit: data leaves on rxd, clock on txd.
      m0_busy_reg <= 1'b1;
      m0_rx_reg <= 1'b0;
      m0_phase_reg <= 1'b0;
      m0_bit_reg <= 3'h0;
      m0_sh_reg <= buf_wdata;
      rxd_out_reg <= buf_wdata[0];
      rxd_oe_reg <= 1'b1;
      tx_busy_reg <= 1'b0;
      txd_reg <= `FMSP_IDLE_LINE;
    end else if (buf_wr) begin
      // Stop, ninth bit, data and start are loaded together; the 8-bit mode gets
      // a 1 in the ninth position so its stop bit ends the frame one bit sooner.
      tx_sh_reg <= {1'b1, (nine_bit ? tx_ninth_bit_reg : 1'b1), buf_wdata, 1'b0};
      tx_busy_reg <= 1'b1;
      tx_wait_reg <= 1'b1;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 4'h0;
      m0_busy_reg <= 1'b0;
      rxd_oe_reg <= 1'b0;
    end else begin
      if (m0_rx_start) begin
        m0_busy_reg <= 1'b1;
        m0_rx_reg <= 1'b1;
        m0_phase_reg <= 1'b0;
        m0_bit_reg <= 3'h0;
        rxd_oe_reg <= 1'b0;
      end else if (m0_busy_reg && shift_tick) begin
        if (!m0_phase_reg) begin
          txd_reg <= 1'b0;
          m0_phase_reg <= 1'b1;
        end else begin
          // Rising shift clock: we move on to our next bit and sample theirs; the far end samples ours on the falling edge.
          txd_reg <= 1'b1;
          m0_phase_reg <= 1'b0;
          m0_bit_reg <= m0_bit_reg + 3'h1;
          m0_sh_reg <= m0_rx_reg ? m0_rx_byte : {1'b1, m0_sh_reg[7:1]};
          if (!m0_rx_reg) begin
            rxd_out_reg <= m0_sh_reg[1];
          end
          if (m0_done) begin
            m0_busy_reg <= 1'b0;
            rxd_oe_reg <= 1'b0;
            rxd_out_reg <= `FMSP_IDLE_LINE;
          end
        end
      end
      if (tx_busy_reg && tx_tick) begin
        if (tx_wait_reg) begin
          tx_wait_reg <= 1'b0;
          txd_reg <= tx_sh_reg[0];
          tx_cnt_reg <= 4'h0;
        end else if (tx_cnt_reg == `FMSP_TICKS_PER_BIT) begin
          tx_cnt_reg <= 4'h0;
          if (tx_bit_reg == tx_last_bit) begin
            tx_busy_reg <= 1'b0;
          end else begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            txd_reg <= tx_sh_reg[1];
          end
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // UART receiver
  // ----------------------------------------------------------------
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;

  reg [1:0] rx_state_reg;
  reg [3:0] rx_cnt_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_sh_reg;
  reg rxd_prev_reg;
  wire rx_sample;
  wire rx_final;
  wire rx_filter_ok;
  wire [3:0] rx_last_bit;
  wire uart_accept;
  wire fifo_push;
  wire [8:0] fifo_in_data;

  assign rx_sample = rx_tick && (rx_cnt_reg == `FMSP_TICKS_PER_BIT);
  // Last sample is mid stop bit: index 9 for 8-bit frames, 10 for 9-bit frames.
  assign rx_last_bit = nine_bit ? `FMSP_LAST_BIT_UART9 : `FMSP_LAST_BIT_UART8;
  assign rx_final = (rx_state_reg == RX_BITS) && rx_sample && (rx_bit_reg == rx_last_bit - 4'h1);
  // In 8-bit frames the stop bit is still on rxd_in; in 9-bit frames rx_sh_reg[8] is the ninth data bit.
  assign rx_filter_ok = !multiproc_filter_reg ||
                        (nine_bit ? rx_sh_reg[8] : rxd_in);
  assign uart_accept = rx_final && !rx_done_flag_reg && rx_filter_ok;
  assign fifo_push = uart_accept || (m0_done && m0_rx_reg && !rx_done_flag_reg);
  assign fifo_in_data = (m0_done && m0_rx_reg) ? {rx_ninth_bit_reg, m0_rx_byte} :
                        (nine_bit ? rx_sh_reg : {rxd_in, rx_sh_reg[8:1]});

  always @(posedge clock) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rxd_prev_reg <= `FMSP_IDLE_LINE;
    end else begin
      rxd_prev_reg <= rxd_in;
      case (rx_state_reg)
        RX_IDLE: begin
          if (!shift_mode && rx_allow_reg && rxd_prev_reg && !rxd_in) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == `FMSP_MID_TICK) begin
              if (rxd_in) begin
                rx_state_reg <= RX_IDLE;
              end else begin
                rx_state_reg <= RX_BITS;
                rx_cnt_reg <= 4'h0;
                rx_bit_reg <= 4'h0;
              end
            end
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
          end
          if (rx_sample) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg < 4'h9) begin
              rx_sh_reg <= {rxd_in, rx_sh_reg[8:1]};
            end
            // The shifter is free again at once, so a second frame may start
            // while the previous byte waits unread.
            if (rx_final) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  fmsp_rx_fifo u_rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(!rx_done_flag_reg),
    .out_data(fifo_out_data)
  );
endmodule

// ---- testbench/fmsp_serial_port_chk.sv ----
// Purpose: Port-level checks for the four-mode serial port.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/10ps
module fmsp_serial_port_chk (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register side
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  input wire [7:0] ctrl_rdata,
  input wire buf_wr,
  input wire [7:0] buf_rdata,
  // Pins
  input wire rxd_out,
  input wire rxd_oe,
  input wire txd_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire shift_m = ctrl_rdata[7:6] == 2'h0;
  // ----------------
  // Sequences
  // ----------------
  sequence s_low_phase;
    (!txd_out)[*6] ##1 txd_out;
  endsequence
  sequence s_stop_hold;
    txd_out[*8];
  endsequence
  // ----------------
  // Properties
  // ----------------
  property p_ctrl_store;
    ctrl_wr |=> ctrl_rdata[7:3] == $past(ctrl_wdata[7:3]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control not stored");
  property p_tx_hold;
    ctrl_rdata[1] && !ctrl_wr |=> ctrl_rdata[1];
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flag cleared");
  property p_rx_hold;
    ctrl_rdata[0] && !ctrl_wr |=> ctrl_rdata[0];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx flag cleared");
  property p_tx_start;
    buf_wr && !shift_m |=> ##[0:8] !txd_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  property p_stop_high;
    $rose(ctrl_rdata[1]) && !$past(ctrl_wr) && !shift_m |-> s_stop_hold;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("flag not at stop bit");
  property p_shift_end;
    $rose(ctrl_rdata[1]) && !$past(ctrl_wr) && shift_m |-> !rxd_oe && rxd_out;
  endproperty
  a_shift_end: assert property (p_shift_end) else $error("data pin not released");
  property p_shift_clk;
    $fell(txd_out) && shift_m |-> s_low_phase;
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock phase");
  property p_shift_data;
    rxd_oe && $past(rxd_oe) && !txd_out |-> $stable(rxd_out);
  endproperty
  a_shift_data: assert property (p_shift_data) else $error("data moved in low phase");
  property p_buf_update;
    $changed(buf_rdata) |-> $rose(ctrl_rdata[0]);
  endproperty
  a_buf_update: assert property (p_buf_update) else $error("buffer changed alone");
  property p_rx_allow;
    $rose(ctrl_rdata[0]) && !$past(ctrl_wr) |-> ctrl_rdata[4];
  endproperty
  a_rx_allow: assert property (p_rx_allow) else $error("receive while disabled");
endmodule

bind fmsp_serial_port fmsp_serial_port_chk chk_u (.clock(clock), .rst_n(rst_n),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .buf_wr(buf_wr),
  .buf_rdata(buf_rdata), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));

// ---- testbench/fmsp_remote_dev.sv ----
// Purpose: Remote serial device facing the port's pins.
// Assumes: Bit lengths in core clocks come from the bench.
// Notes: Frames are sampled at mid-bit, eleven samples each.
`timescale 1ns/10ps
module fmsp_remote_dev (
  // Clock
  input wire clock,
  // Line state and bit lengths
  input wire txd,
  input wire dline,
  input wire oe,
  input wire shift_mode,
  input wire [7:0] tx_cyc,
  input wire [7:0] rx_cyc,
  // Data line drive
  output reg line_out
);
  reg [10:0] got = 11'h000;
  reg [7:0] sh_got = 8'h00;
  reg [7:0] feed = 8'h00;
  reg [2:0] fidx = 3'h0;
  integer got_n = 0;
  integer sh_n = 0;
  integer sh_c = 0;
  integer i;
  initial line_out = 1'b1;
  // ----------------
  // Capture
  // ----------------
  initial forever begin
    @(negedge txd);
    if (!shift_mode) begin
      repeat (tx_cyc / 2) @(posedge clock);
      for (i = 0; i < 11; i = i + 1) begin
        got[i] = txd;
        repeat (tx_cyc) @(posedge clock);
      end
      got_n = got_n + 1;
    end else if (oe) begin
      sh_got = {dline, sh_got[7:1]};
      sh_c = (sh_c + 1) % 8;
      if (sh_c == 0)
        sh_n = sh_n + 1;
    end
  end
  // ----------------
  // Shift-mode feed
  // ----------------
  // Each bit is held only across the sampling edge, then inverted, so a
  // sample taken late cannot pass by luck.
  initial forever begin
    @(negedge txd);
    if (shift_mode && !oe) begin
      line_out <= feed[fidx];
      fidx = fidx + 3'h1;
      @(posedge txd);
      repeat (2) @(posedge clock);
      line_out <= ~line_out;
    end
  end
  task automatic send(input [10:0] fr);
    integer k;
    for (k = 0; k < 11; k = k + 1) begin
      line_out <= fr[k];
      repeat (rx_cyc) @(posedge clock);
    end
  endtask
  task load(input [7:0] b);
    feed = b;
    fidx = 3'h0;
  endtask
endmodule

// ---- testbench/test_four_mode_serial_port.sv ----
// Purpose: Self-checking bench for the four-mode serial port.
// Assumes: Timer overflows arrive every 2 and every 3 clocks.
// Notes: Random data from a fixed seed; filters and lost frames are forced.
`timescale 1ns/10ps
module test_four_mode_serial_port;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg ctrl_wr = 1'b0;
  reg [7:0] ctrl_wdata = 8'h00;
  reg buf_wr = 1'b0;
  reg [7:0] buf_wdata = 8'h00;
  reg baud_doubler = 1'b0;
  reg tx_timer_select = 1'b0;
  reg rx_timer_select = 1'b0;
  reg timer1_ovf = 1'b0;
  reg timer2_ovf = 1'b0;
  reg [7:0] tcnt = 8'h00;
  reg [1:0] t3 = 2'h0;
  reg [1:0] cur_mode = 2'h0;
  reg [7:0] d;
  reg nb;
  wire [7:0] ctrl_rdata;
  wire [7:0] buf_rdata;
  wire rxd_out;
  wire rxd_oe;
  wire txd_out;
  wire dev_line;
  wire rxd_line = rxd_oe ? rxd_out : dev_line;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer k;
  integer m;
  integer n0;
  function [7:0] bit_len(input [1:0] md, input sel, input dbl);
    bit_len = md == 2'h2 ? (dbl ? 8'h20 : 8'h40) : (sel ? 8'h30 : 8'h20);
  endfunction
  function [10:0] frame(input [1:0] md, input b9, input [7:0] v);
    frame = {1'b1, md == 2'h1 ? 1'b1 : b9, v, 1'b0};
  endfunction
  wire [7:0] tx_cyc = bit_len(cur_mode, tx_timer_select, baud_doubler);
  wire [7:0] rx_cyc = bit_len(cur_mode, rx_timer_select, baud_doubler);
  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    tcnt <= tcnt + 8'h01;
    t3 <= t3 == 2'h2 ? 2'h0 : t3 + 2'h1;
    timer1_ovf <= tcnt[0];
    timer2_ovf <= t3 == 2'h0;
  end
  fmsp_serial_port dut_u (.clock(clock), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
    .buf_rdata(buf_rdata), .baud_doubler(baud_doubler), .tx_timer_select(tx_timer_select),
    .rx_timer_select(rx_timer_select), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  fmsp_remote_dev dev_u (.clock(clock), .txd(txd_out), .dline(rxd_line), .oe(rxd_oe),
    .shift_mode(cur_mode == 2'h0), .tx_cyc(tx_cyc), .rx_cyc(rx_cyc), .line_out(dev_line));
  // ----------------
  // Tasks
  // ----------------
  task check(input [19:0] e, input [19:0] g, input [47:0] nm);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input is_buf, input [7:0] v);
    ctrl_wdata <= v;
    buf_wdata <= v;
    ctrl_wr <= !is_buf;
    buf_wr <= is_buf;
    @(posedge clock);
    ctrl_wr <= 1'b0;
    buf_wr <= 1'b0;
    @(posedge clock);
  endtask
  task wait_dev(input integer c0, input is_sh);
    for (k = 0; k < 2000 && (is_sh ? dev_u.sh_n : dev_u.got_n) == c0; k = k + 1)
      @(posedge clock);
  endtask
  task rx_frame(input [1:0] md, input f, input en, input b9, input pre);
    reg [7:0] v;
    reg [7:0] old;
    reg ok;
    v = 8'($urandom);
    old = buf_rdata;
    ok = en && !pre && (!f || b9);
    wr(1'b0, {md, f, en, 3'h0, pre});
    dev_u.send({1'b1, b9, v, 1'b0});
    repeat (4) @(posedge clock);
    check(ok ? v : old, buf_rdata, "rxbuf");
    check({pre | ok, ok & b9}, {ctrl_rdata[0], ctrl_rdata[2]}, "rxflag");
  endtask
  task wrap_up;
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    void'($urandom(32'hcfdd));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check({txd_out, rxd_oe, rxd_out, buf_rdata, ctrl_rdata}, {3'h5, 16'h0000}, "reset");
    repeat (4) begin
      d = 8'($urandom);
      d[4] = 1'b0;
      if (d[7:6] == 2'h0)
        d[5] = 1'b0;
      wr(1'b0, d);
      check(d, ctrl_rdata, "ctrl");
    end
    for (m = 1; m < 4; m = m + 1) begin
      baud_doubler <= 1'($urandom);
      tx_timer_select <= 1'($urandom);
      rx_timer_select <= 1'($urandom);
      cur_mode = 2'(m);
      repeat (2) begin
        d = 8'($urandom);
        nb = 1'($urandom);
        wr(1'b0, {cur_mode, 2'h0, nb, 3'h0});
        n0 = dev_u.got_n;
        wr(1'b1, d);
        wait_dev(n0, 1'b0);
        check(frame(cur_mode, nb, d), dev_u.got, "txfrm");
        check(1'b1, ctrl_rdata[1], "tdone");
        // In 9-bit modes the last sample falls mid stop bit; let the stop bit end before the next write.
        repeat (80) @(posedge clock);
      end
      rx_frame(cur_mode, 1'b0, 1'b1, 1'($urandom), 1'b0);
      rx_frame(cur_mode, 1'b1, 1'b1, 1'b0, 1'b0);
      rx_frame(cur_mode, 1'b1, 1'b1, 1'b1, 1'b0);
      rx_frame(cur_mode, 1'b0, 1'b1, 1'b1, 1'b1);
      rx_frame(cur_mode, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    cur_mode = 2'h0;
    wr(1'b0, 8'h00);
    d = 8'($urandom);
    n0 = dev_u.sh_n;
    wr(1'b1, d);
    wait_dev(n0, 1'b1);
    check(d, dev_u.sh_got, "shtx");
    repeat (12) @(posedge clock);
    check(1'b1, ctrl_rdata[1], "tdone");
    d = 8'($urandom);
    dev_u.load(d);
    wr(1'b0, 8'h10);
    for (k = 0; k < 400 && ctrl_rdata[0] !== 1'b1; k = k + 1)
      @(posedge clock);
    check(d, buf_rdata, "shrx");
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule
